// ---- src/clock_source_control_regs.sv ----
// Control registers and tick-level clock model of the clock generator.
// Assumes reference clock pins are asynchronous to clk; stop and debug
// levels come from logic on clk. Clocks are modelled as one-cycle ticks.
//
// Summary of operation
// - Source select picks loop, internal or external.
// - Reserved source encoding acts as loop select.
// - Reference divider divides by two to field.
// - Reference divider resets to divide by one.
// - Reference select bit picks internal or external.
// - Internal reference output gated by its enable.
// - Internal reference kept in stop when allowed.
// - Bus divider divides by 1, 2, 4, 8.
// - Bus divider resets to divide by two.
// - Range bit drives oscillator frequency range.
// - Gain bit drives oscillator high-gain mode.
// - Low-power bit disables loop when bypassed.
// - Source bit requests crystal or external clock.
// - External reference output gated by its enable.
// - External reference kept in stop when allowed.
// - Bus clock runs at half divided output.
// - Loop locks to 512 times divided reference.
// - Reset leaves internal-reference loop mode engaged.
// - Mode status follows source select after synchronisation.
//
// Added by the designer: the address-and-strobe port and the register offsets.
`default_nettype none
module clock_source_control_regs (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       stop_mode,
  input  wire logic       debug_mode,
  input  wire logic       int_ref_clk,
  input  wire logic       ext_ref_clk,
  output logic            int_ref_enable,
  output logic            int_ref_clock_out,
  output logic            ext_ref_enable,
  output logic            ext_ref_clock_out,
  output logic            osc_high_range,
  output logic            osc_high_gain,
  output logic            ext_source_oscillator,
  output logic            loop_enable,
  output logic            loop_tick,
  output logic            divided_output_clock,
  output logic            bus_clock,
  output logic      [1:0] mode_status
);
  // Width of the period counters, declared ahead of its first use.
  localparam int PERIOD_W = clock_generator_pkg::PERIOD_W;

  logic [7:0] ctrl_one_r;       // The first control register.
  logic [7:0] ctrl_two_r;       // The second control register.
  logic [1:0] eff_src;          // Source select after reserved mapping.
  logic [1:0] status_stage_r;   // First stage of the status crossing.
  logic       pre_int_mode_r;   // An internal mode ran before stop.
  logic       pre_ext_mode_r;   // An external mode ran before stop.
  logic [1:0] pin_meta_r;       // First synchroniser stage per pin.
  logic [1:0] pin_sync_r;       // Second synchroniser stage per pin.
  logic [1:0] pin_prev_r;       // Previous synchronised level per pin.
  logic [1:0] pin_edge;         // Rising edge tick per reference pin.
  logic [1:0] ref_pins;         // Reference pins as a vector.
  logic       loop_ref_tick;    // Reference edge chosen for the loop.
  logic       div_ref_tick;     // Reference tick after the divider.
  logic [PERIOD_W-1:0] per_cnt_r;  // Cycles since the last divided tick.
  logic [PERIOD_W-1:0] loop_per_r; // Loop period in clk cycles.
  logic [PERIOD_W-1:0] loop_cnt_r; // Loop period count-up from zero.
  logic       src_tick;         // Tick of the selected source clock.
  logic       div_tick;         // Tick after the bus divider.
  logic       int_mode;         // Present mode uses the internal ref.
  logic       ext_mode;         // Present mode uses the external ref.

  assign ref_pins = {ext_ref_clk, int_ref_clk};

  // The reserved encoding falls back to the loop output.
  always_comb begin
    eff_src = ctrl_one_r[clock_generator_pkg::SRC_LO +: 2];
    if (eff_src == 2'h3) begin
      eff_src = clock_generator_pkg::SRC_LOOP;
    end
  end

  // Internal modes are loop with internal reference or internal bypass.
  always_comb begin
    int_mode = (eff_src == clock_generator_pkg::SRC_INT) ||
               ((eff_src == clock_generator_pkg::SRC_LOOP) &&
                ctrl_one_r[clock_generator_pkg::LOOP_REFERENCE_SELECT_BIT]);
    ext_mode = (eff_src == clock_generator_pkg::SRC_EXT) ||
               ((eff_src == clock_generator_pkg::SRC_LOOP) &&
                !ctrl_one_r[clock_generator_pkg::LOOP_REFERENCE_SELECT_BIT]);
  end

  // Register writes land on the clock edge of the write strobe.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_one_r <= clock_generator_pkg::CTRL_ONE_RESET;
      ctrl_two_r <= clock_generator_pkg::CTRL_TWO_RESET;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == clock_generator_pkg::OFF_CTRL_ONE) begin
        ctrl_one_r <= reg_wdata;
      end
      if (reg_addr == clock_generator_pkg::OFF_CTRL_TWO) begin
        ctrl_two_r <= reg_wdata;
      end
    end
  end

  // Read data stands one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_rd) begin
      unique case (reg_addr)
        clock_generator_pkg::OFF_CTRL_ONE: reg_rdata <= ctrl_one_r;
        clock_generator_pkg::OFF_CTRL_TWO: reg_rdata <= ctrl_two_r;
        clock_generator_pkg::OFF_STATUS: begin
          reg_rdata <= 8'(mode_status) << clock_generator_pkg::STATUS_LO;
        end
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Status lags the select by two stages, as the real mode switch crosses
  // into the selected clock domain before it reports.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_stage_r <= clock_generator_pkg::SRC_LOOP;
      mode_status    <= clock_generator_pkg::SRC_LOOP;
    end else if (clk_en) begin
      status_stage_r <= eff_src;
      mode_status    <= status_stage_r;
    end
  end

  // Each reference pin passes two flip-flops before edge detection.
  for (genvar g = 0; g < 2; g++) begin : g_pin
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        pin_meta_r[g] <= 1'b0;
        pin_sync_r[g] <= 1'b0;
        pin_prev_r[g] <= 1'b0;
      end else if (clk_en) begin
        pin_meta_r[g] <= ref_pins[g];
        pin_sync_r[g] <= pin_meta_r[g];
        pin_prev_r[g] <= pin_sync_r[g];
      end
    end
    assign pin_edge[g] = pin_sync_r[g] && !pin_prev_r[g];
  end

  // The loop reference is the internal pin when the select bit is one.
  assign loop_ref_tick = ctrl_one_r[clock_generator_pkg::LOOP_REFERENCE_SELECT_BIT] ?
                         pin_edge[0] : pin_edge[1];

  // Reference divider ahead of the loop.
  pow2_tick_divider #(
    .SEL_W (3),
    .CNT_W (clock_generator_pkg::REFERENCE_DIVIDER_CNT_W)
  ) u_ref_div (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .in_tick  (loop_ref_tick),
    .sel      (ctrl_one_r[clock_generator_pkg::REFERENCE_DIVIDER_LO +: 3]),
    .out_tick (div_ref_tick)
  );

  // Frequency lock: measure the divided reference period and run the loop
  // at that period over 512. The period is quantised to whole clk cycles,
  // so the modelled loop frequency is only as fine as clk allows.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      per_cnt_r  <= '0;
      loop_per_r <= PERIOD_W'(1);
    end else if (clk_en && loop_enable) begin
      if (div_ref_tick) begin
        // Restart at one so that the count at the next tick is the full period.
        per_cnt_r <= PERIOD_W'(1);
        if ((per_cnt_r >> clock_generator_pkg::LOOP_MULT_LOG2) != '0) begin
          loop_per_r <= per_cnt_r >> clock_generator_pkg::LOOP_MULT_LOG2;
        end else begin
          // A reference too fast for clk runs the loop at its ceiling.
          loop_per_r <= PERIOD_W'(1);
        end
      end else if (per_cnt_r != '1) begin
        per_cnt_r <= per_cnt_r + PERIOD_W'(1);
      end
    end
  end

  // Loop oscillator: one tick per measured loop period while enabled.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      loop_cnt_r <= '0;
      loop_tick  <= 1'b0;
    end else if (clk_en) begin
      loop_tick <= 1'b0;
      if (!loop_enable) begin
        loop_cnt_r <= '0;
      end else if (loop_cnt_r + PERIOD_W'(1) >= loop_per_r) begin
        loop_cnt_r <= '0;
        loop_tick  <= 1'b1;
      end else begin
        loop_cnt_r <= loop_cnt_r + PERIOD_W'(1);
      end
    end
  end

  // The loop stops in stop, and in bypass modes with low power set
  // unless the debugger needs its clock.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      loop_enable <= 1'b1;
    end else if (clk_en) begin
      loop_enable <= !stop_mode &&
        !((eff_src != clock_generator_pkg::SRC_LOOP) &&
          ctrl_two_r[clock_generator_pkg::LP_BIT] && !debug_mode);
    end
  end

  // Source selection ahead of the bus divider; nothing runs in stop.
  always_comb begin
    unique case (eff_src)
      clock_generator_pkg::SRC_INT: src_tick = pin_edge[0];
      clock_generator_pkg::SRC_EXT: src_tick = pin_edge[1];
      default:                      src_tick = loop_tick;
    endcase
    src_tick = src_tick && !stop_mode;
  end

  // Bus divider producing the divided output clock ticks.
  pow2_tick_divider #(
    .SEL_W (2),
    .CNT_W (clock_generator_pkg::BUS_DIVIDER_CNT_W)
  ) u_bus_div (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .in_tick  (src_tick),
    .sel      (ctrl_two_r[clock_generator_pkg::BUS_DIVIDER_LO +: 2]),
    .out_tick (div_tick)
  );

  // Divided output toggles on each tick; the bus clock on every second.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      divided_output_clock <= 1'b0;
      bus_clock            <= 1'b0;
    end else if (clk_en && div_tick) begin
      divided_output_clock <= !divided_output_clock;
      if (divided_output_clock) begin
        bus_clock <= !bus_clock;
      end
    end
  end

  // Remember which reference the mode used while not stopped.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_int_mode_r <= 1'b1;
      pre_ext_mode_r <= 1'b0;
    end else if (clk_en && !stop_mode) begin
      pre_int_mode_r <= int_mode;
      pre_ext_mode_r <= ext_mode;
    end
  end

  // Reference enables: on while running when used or requested; in stop
  // only if the keep bit is set and the reference was in use or requested.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_ref_enable <= 1'b1;
      ext_ref_enable <= 1'b0;
    end else if (clk_en) begin
      if (stop_mode) begin
        int_ref_enable <= ctrl_one_r[clock_generator_pkg::INT_REF_STOP_KEEP_BIT] &&
          (ctrl_one_r[clock_generator_pkg::INT_REF_OUTPUT_ENABLE_BIT] || pre_int_mode_r);
        ext_ref_enable <= ctrl_two_r[clock_generator_pkg::EXT_REF_STOP_KEEP_BIT] &&
          (ctrl_two_r[clock_generator_pkg::EXT_REF_OUTPUT_ENABLE_BIT] || pre_ext_mode_r);
      end else begin
        int_ref_enable <= int_mode || ctrl_one_r[clock_generator_pkg::INT_REF_OUTPUT_ENABLE_BIT];
        ext_ref_enable <= ext_mode || ctrl_two_r[clock_generator_pkg::EXT_REF_OUTPUT_ENABLE_BIT];
      end
    end
  end

  // Gated reference outputs and oscillator controls.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_ref_clock_out     <= 1'b0;
      ext_ref_clock_out     <= 1'b0;
      osc_high_range        <= 1'b0;
      osc_high_gain         <= 1'b0;
      ext_source_oscillator <= 1'b0;
    end else if (clk_en) begin
      int_ref_clock_out <= pin_sync_r[0] && int_ref_enable &&
                           ctrl_one_r[clock_generator_pkg::INT_REF_OUTPUT_ENABLE_BIT];
      ext_ref_clock_out <= pin_sync_r[1] && ext_ref_enable &&
                           ctrl_two_r[clock_generator_pkg::EXT_REF_OUTPUT_ENABLE_BIT];
      osc_high_range        <= ctrl_two_r[clock_generator_pkg::RANGE_BIT];
      osc_high_gain         <= ctrl_two_r[clock_generator_pkg::HGO_BIT];
      ext_source_oscillator <= ctrl_two_r[clock_generator_pkg::EXT_SOURCE_OSCILLATOR_BIT];
    end
  end

  // Checks on the logic above.
  a_reserved_as_loop: assert property (
    @(posedge clk) disable iff (sys_rst)
    ctrl_one_r[clock_generator_pkg::SRC_LO +: 2] == 2'h3
    |-> src_tick == (loop_tick && !stop_mode))
    else $error("Reserved source encoding did not select the loop.");
  a_read_ctrl_one: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && reg_rd && reg_addr == clock_generator_pkg::OFF_CTRL_ONE
    |=> reg_rdata == $past(ctrl_one_r))
    else $error("Read of first control register returned wrong data.");
  a_write_ctrl_two: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && reg_wr && reg_addr == clock_generator_pkg::OFF_CTRL_TWO
    |=> ctrl_two_r == $past(reg_wdata))
    else $error("Write to second control register was lost.");
  a_status_lag: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en ##1 clk_en ##1 1'b1 |-> mode_status == $past(eff_src, 2))
    else $error("Mode status does not follow the select two cycles late.");
  a_stop_int_off: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && stop_mode && !ctrl_one_r[clock_generator_pkg::INT_REF_STOP_KEEP_BIT]
    |=> !int_ref_enable)
    else $error("Internal reference left running in stop.");
  a_stop_ext_off: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && stop_mode && !ctrl_two_r[clock_generator_pkg::EXT_REF_STOP_KEEP_BIT]
    |=> !ext_ref_enable)
    else $error("External reference left running in stop.");
  a_loop_lp_off: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && eff_src != clock_generator_pkg::SRC_LOOP && !debug_mode &&
    ctrl_two_r[clock_generator_pkg::LP_BIT] |=> !loop_enable)
    else $error("Loop stayed enabled in low-power bypass.");
  a_int_out_gate: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && !ctrl_one_r[clock_generator_pkg::INT_REF_OUTPUT_ENABLE_BIT]
    |=> !int_ref_clock_out)
    else $error("Internal reference output active while disabled.");
  a_bus_half: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && div_tick && divided_output_clock |=> bus_clock != $past(bus_clock))
    else $error("Bus clock did not toggle on every second divided tick.");
endmodule : clock_source_control_regs
`default_nettype wire

// ---- src/clock_generator_pkg.sv ----
// Constants shared by the clock generator control block and its divider.
// Assumes an 8-bit register port with a 2-bit word address.
`default_nettype none
package clock_generator_pkg;
  // Register word addresses on the plain register port.
  localparam logic [1:0] OFF_CTRL_ONE = 2'h0;
  localparam logic [1:0] OFF_CTRL_TWO = 2'h1;
  localparam logic [1:0] OFF_STATUS   = 2'h2;
  // Reset values: internal-reference loop mode, bus divide by two.
  localparam logic [7:0] CTRL_ONE_RESET = 8'h04;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h40;
  // Field positions of clock_control_one.
  localparam int SRC_LO       = 6;
  localparam int REFERENCE_DIVIDER_LO      = 3;
  localparam int LOOP_REFERENCE_SELECT_BIT    = 2;
  localparam int INT_REF_OUTPUT_ENABLE_BIT  = 1;
  localparam int INT_REF_STOP_KEEP_BIT = 0;
  // Field positions of clock_control_two.
  localparam int BUS_DIVIDER_LO      = 6;
  localparam int RANGE_BIT    = 5;
  localparam int HGO_BIT      = 4;
  localparam int LP_BIT       = 3;
  localparam int EXT_SOURCE_OSCILLATOR_BIT    = 2;
  localparam int EXT_REF_OUTPUT_ENABLE_BIT  = 1;
  localparam int EXT_REF_STOP_KEEP_BIT = 0;
  // Position of the mode status field in the status register.
  localparam int STATUS_LO    = 2;
  // Source select encodings.
  localparam logic [1:0] SRC_LOOP = 2'h0;
  localparam logic [1:0] SRC_INT  = 2'h1;
  localparam logic [1:0] SRC_EXT  = 2'h2;
  // The loop runs at two to this power times the divided reference.
  localparam int LOOP_MULT_LOG2 = 9;
  // Widths of the reference and bus divider counters.
  localparam int REFERENCE_DIVIDER_CNT_W = 7;
  localparam int BUS_DIVIDER_CNT_W = 3;
  // Width of the reference period measurement counter.
  localparam int PERIOD_W = 16;
endpackage : clock_generator_pkg
`default_nettype wire

// ---- src/pow2_tick_divider.sv ----
// Divides a stream of one-cycle ticks by two raised to a select value.
// Assumes the input ticks and select are synchronous to clk.
`default_nettype none
module pow2_tick_divider #(
  parameter int SEL_W = 3,
  parameter int CNT_W = 7
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic             in_tick,
  input  wire logic [SEL_W-1:0] sel,
  output logic                  out_tick
);
  logic [CNT_W-1:0] cnt_r;  // Counts input ticks.
  logic [CNT_W-1:0] mask;   // Low bits that must be all ones to emit.

  // A select of n passes every 2**n-th tick; select zero passes all.
  always_comb begin
    mask = CNT_W'((1 << sel) - 1);
  end

  // The counter only advances on input ticks, so the ratio is exact.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r    <= '0;
      out_tick <= 1'b0;
    end else if (clk_en) begin
      out_tick <= in_tick && ((cnt_r & mask) == mask);
      if (in_tick) begin
        cnt_r <= cnt_r + CNT_W'(1);
      end
    end
  end
endmodule : pow2_tick_divider
`default_nettype wire

// ---- tb/test_clock_source_control_regs.sv ----
// Self-checking testbench for the clock generator control registers.
// Assumes the package and the design files are compiled before this file.
`default_nettype none
module test_clock_source_control_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk;         // Bus clock, 200 MHz.
  logic       sys_rst;     // Asynchronous reset, active high.
  logic       clk_en;      // Clock enable into the block.
  logic [1:0] reg_addr;    // Register word address.
  logic [7:0] reg_wdata;   // Register write data.
  logic       reg_wr;      // Write strobe.
  logic       reg_rd;      // Read strobe.
  logic [7:0] reg_rdata;   // Read data, one cycle after the strobe.
  logic       stop_mode;   // Stop level.
  logic       debug_mode;  // Debug active level.
  logic       int_ref_clk; // Internal reference pin, period 16 cycles.
  logic       ext_ref_clk; // External reference pin, period 10 cycles.
  logic       ire, irc, ere, erc, orng, ogain, osrc, loop_en, loop_tick, doc, bus_clk;
  logic [1:0] mode_status; // Mode status from the block.
  int         fails = 0;   // Mismatches seen.
  int         checks_done = 0; // Comparisons made.
  int         cnt [5] = '{default: 0}; // Running event counts.
  int         got [5];     // Event counts over the last window.
  int         rc = 0;      // Reference pin phase counter.
  logic       doc_q, bus_q, irc_q, erc_q; // Previous levels for edge counting.

  clock_source_control_regs uut (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .stop_mode(stop_mode), .debug_mode(debug_mode), .int_ref_clk(int_ref_clk),
    .ext_ref_clk(ext_ref_clk), .int_ref_enable(ire), .int_ref_clock_out(irc),
    .ext_ref_enable(ere), .ext_ref_clock_out(erc), .osc_high_range(orng),
    .osc_high_gain(ogain), .ext_source_oscillator(osrc), .loop_enable(loop_en),
    .loop_tick(loop_tick), .divided_output_clock(doc), .bus_clock(bus_clk),
    .mode_status(mode_status));

  // Clock generator.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Reference pins; the two periods differ so a wrong source choice shows up.
  always @(posedge clk) begin
    rc <= rc + 1;
    if (rc % 8 == 0) int_ref_clk <= ~int_ref_clk;
    if (rc % 5 == 0) ext_ref_clk <= ~ext_ref_clk;
  end

  // Event counters: output toggles, bus toggles, loop ticks, gated reference rises.
  always @(posedge clk) begin
    cnt[0] <= cnt[0] + int'(doc != doc_q);
    cnt[1] <= cnt[1] + int'(bus_clk != bus_q);
    cnt[2] <= cnt[2] + int'(loop_tick);
    cnt[3] <= cnt[3] + int'(irc && !irc_q);
    cnt[4] <= cnt[4] + int'(erc && !erc_q);
    doc_q <= doc;
    bus_q <= bus_clk;
    irc_q <= irc;
    erc_q <= erc;
  end

  // Compares one value and reports a mismatch at once.
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Counts are quantised to clock cycles, so a small tolerance is allowed.
  function automatic logic [7:0] near(input int c, input int e, input int t);
    return {7'h00, (c >= e - t) && (c <= e + t)};
  endfunction : near

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic window(input int n);
    int base [5];
    @(posedge clk);
    base = cnt;
    repeat (n) @(posedge clk);
    foreach (got[i]) got[i] = cnt[i] - base[i];
  endtask : window

  // One-cycle write; the slave never stalls.
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic w1(input logic [7:0] d);
    wr(clock_generator_pkg::OFF_CTRL_ONE, d);
  endtask : w1

  task automatic w2(input logic [7:0] d);
    wr(clock_generator_pkg::OFF_CTRL_TWO, d);
  endtask : w2

  // Read data stand from the cycle after the strobe until the next read.
  task automatic rd_chk(input string what, input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    check(what, reg_rdata, e);
  endtask : rd_chk

  task automatic t_reset();
    settle(0);
    check("ire", {7'h00, ire}, 8'h01);
    check("loop_en", {7'h00, loop_en}, 8'h01);
    check("mode", {6'h00, mode_status}, 8'h00);
    rd_chk("one", clock_generator_pkg::OFF_CTRL_ONE, 8'h04);
    rd_chk("two", clock_generator_pkg::OFF_CTRL_TWO, 8'h40);
  endtask : t_reset

  task automatic t_regs();
    w1(8'h5a);
    w2(8'ha5);
    rd_chk("one", clock_generator_pkg::OFF_CTRL_ONE, 8'h5a);
    rd_chk("two", clock_generator_pkg::OFF_CTRL_TWO, 8'ha5);
    wr(2'h3, 8'hff);
    rd_chk("unmapped", 2'h3, 8'h00);
    wr(clock_generator_pkg::OFF_STATUS, 8'hff);
    rd_chk("status", clock_generator_pkg::OFF_STATUS, 8'h04);
    // A strobe while the enable is low must be ignored.
    @(posedge clk);
    clk_en <= 1'b0;
    w1(8'h00);
    @(posedge clk);
    clk_en <= 1'b1;
    rd_chk("frozen", clock_generator_pkg::OFF_CTRL_ONE, 8'h5a);
    foreach (got[i]) got[i] = 0;
    for (int v = 0; v < 2; v++) begin
      w2(v ? 8'h34 : 8'h40);
      settle(3);
      check("range", {7'h00, orng}, v[7:0]);
      check("gain", {7'h00, ogain}, v[7:0]);
      check("osc", {7'h00, osrc}, v[7:0]);
    end
  endtask : t_regs

  task automatic t_source();
    logic [1:0] prev;
    logic [1:0] exp;
    prev = 2'h1;
    for (int s = 0; s < 4; s++) begin
      exp = (s == 3) ? 2'h0 : s[1:0];
      w1({s[1:0], 6'h04});
      settle(0);
      check("mode early", {6'h00, mode_status}, {6'h00, prev});
      settle(4);
      check("mode", {6'h00, mode_status}, {6'h00, exp});
      rd_chk("status", clock_generator_pkg::OFF_STATUS, {4'h0, exp, 2'h0});
      prev = exp;
    end
  endtask : t_source

  task automatic t_bus_div();
    w1(8'h44);
    for (int b = 0; b < 4; b++) begin
      w2({b[1:0], 6'h00});
      settle(40);
      window(640);
      check("out toggles", near(got[0], 40 >> b, 2), 8'h01);
      check("bus toggles", near(got[1], 20 >> b, 2), 8'h01);
    end
    w2(8'h00);
    w1(8'h80);
    settle(40);
    window(640);
    check("ext source", near(got[0], 64, 2), 8'h01);
  endtask : t_bus_div

  task automatic t_loop();
    logic [7:0] one [4] = '{8'h3c, 8'h38, 8'h34, 8'h04};
    int         exp [4] = '{256, 512, 512, 1024};
    w2(8'h00);
    for (int i = 0; i < 4; i++) begin
      w1(one[i]);
      settle(5000);
      window(1024);
      check("loop ticks", near(got[2], exp[i], 8), 8'h01);
    end
  endtask : t_loop

  task automatic t_gate();
    for (int e = 0; e < 2; e++) begin
      w1(e ? 8'h06 : 8'h04);
      w2(e ? 8'h42 : 8'h40);
      settle(10);
      window(320);
      check("int out", near(got[3], e ? 20 : 0, e), 8'h01);
      check("ext out", near(got[4], e ? 32 : 0, e), 8'h01);
    end
  endtask : t_gate

  task automatic t_stop();
    logic [7:0] st [4][4] = '{'{8'h04, 8'h41, 8'h00, 8'h00}, '{8'h05, 8'h43, 8'h01, 8'h01},
                              '{8'h81, 8'h41, 8'h00, 8'h01}, '{8'h03, 8'h40, 8'h01, 8'h00}};
    for (int i = 0; i < 4; i++) begin
      w1(st[i][0]);
      w2(st[i][1]);
      repeat (10) @(posedge clk);
      stop_mode <= 1'b1;
      settle(4);
      check("ire stop", {7'h00, ire}, st[i][2]);
      check("ere stop", {7'h00, ere}, st[i][3]);
      check("loop stop", {7'h00, loop_en}, 8'h00);
      @(posedge clk);
      stop_mode <= 1'b0;
      settle(4);
    end
  endtask : t_stop

  task automatic t_lp();
    logic [7:0] lp [4][4] = '{'{8'h44, 8'h48, 8'h00, 8'h00}, '{8'h44, 8'h48, 8'h01, 8'h01},
                              '{8'h44, 8'h40, 8'h00, 8'h01}, '{8'h04, 8'h48, 8'h00, 8'h01}};
    for (int i = 0; i < 4; i++) begin
      w1(lp[i][0]);
      w2(lp[i][1]);
      debug_mode <= lp[i][2][0];
      settle(4);
      check("loop_en", {7'h00, loop_en}, lp[i][3]);
    end
    debug_mode <= 1'b0;
  endtask : t_lp

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // Watchdog: the sequence needs about 30000 cycles, so this leaves ample room.
  initial begin
    repeat (80000) @(posedge clk);
    fails++;
    give_verdict();
  end

  // Main sequence; every input has a value at time zero.
  initial begin
    {sys_rst, clk_en, reg_wr, reg_rd, stop_mode, debug_mode} = 6'b110000;
    {reg_addr, reg_wdata, int_ref_clk, ext_ref_clk} = 12'h000;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_regs();
    t_source();
    t_bus_div();
    t_loop();
    t_gate();
    t_stop();
    t_lp();
    give_verdict();
  end
endmodule : test_clock_source_control_regs
`default_nettype wire
